// ### design/osc_config_decode.sv
// Module: capture and decode of the oscillator configuration fields
// Behaviour
// R1: Source codes 111, 110, 101 select fast RC via divide-by-N, fast RC by 16, low-power RC.
// R2: Code 100 in the source field is reserved and must never be programmed.
// R3: Codes 011, 010, 001, 000 select primary+PLL, primary, fast RC div-N+PLL, plain fast RC.
// R4: Switch mode 1x disables switching and monitor, 01 switching only, 00 both on.
// R5: Lock bit 1 allows one pin mapping change, 0 allows any number.
// R6: Outside crystal modes the second oscillator pin outputs the clock when its bit is 1, else GPIO.
// R7: Primary mode 11 off, 10 high-speed crystal, 01 mid-speed crystal, 00 external clock.
// R8: All fields are captured from configuration memory at reset and held until the next reset.
`timescale 1ns/1ns
`default_nettype none

module osc_config_decode
	import osc_config_pkg::*;
#(
	// Field widths of the configuration word; the layout allows no others
	parameter int unsigned SRC_WIDTH  = SRC_W,
	parameter int unsigned MODE_WIDTH = MODE_W
)
(
	input  wire logic     clk,
	input  wire logic     rst_n,
	input  wire osc_cfg_t cfg_word,
	input  wire logic     cfg_valid,
	input  wire logic     pin_map_write,
	output logic          pin_map_write_accept,
	output logic          cfg_loaded,
	output osc_decoded_t  decoded
);

	// ==========================================================
	// Reset synchroniser
	// Asynchronous assert, clocked release so all state leaves reset on one edge
	logic rst_sync1_reg;
	logic rst_sync2_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end

	// Internal reset for every other register
	wire logic rst_int_n = rst_sync2_reg;

	// ==========================================================
	// Elaboration checks
	if (SRC_WIDTH != SRC_W) begin : g_src_width_check
		$error("Source field width does not match the configuration word");
	end
	if (MODE_WIDTH != MODE_W ||
	    SRC_WIDTH + 2 * MODE_WIDTH + 2 != $bits(osc_cfg_t)) begin : g_mode_width_check
		$error("Mode field width does not match the configuration word");
	end

	// ==========================================================
	// Configuration capture
	// Memory readout comes from the device clock domain, so no synchroniser.
	osc_cfg_t     cfg_reg;
	osc_cfg_t     cfg_next;
	logic         loaded_reg;
	logic         loaded_next;
	logic         map_done_reg;
	logic         map_done_next;
	logic         accept_reg;
	logic         accept_next;
	osc_decoded_t dec_reg;
	osc_decoded_t dec_next;

	always_comb begin
		cfg_next    = cfg_reg;
		loaded_next = loaded_reg;
		// Only the first valid word after reset counts; later ones are ignored
		if (!loaded_reg && cfg_valid) begin // [R8]
			cfg_next    = cfg_word;
			loaded_next = 1'b1;
		end
	end

	// ==========================================================
	// Capture registers
	// Reset value is the safe start-up word, not zeros
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			cfg_reg    <= CFG_RST;
			loaded_reg <= 1'b0;
		end else begin
			cfg_reg    <= cfg_next;
			loaded_reg <= loaded_next;
		end
	end

	// ==========================================================
	// Pin mapping change gate
	// Writes before the word is loaded are ignored
	// A refused request leaves no trace: no accept pulse, no state change
	always_comb begin
		map_done_next = map_done_reg;
		accept_next   = 1'b0;
		if (loaded_reg && pin_map_write) begin
			if (!(cfg_reg.pin_map_single_change && map_done_reg)) begin // [R5]
				accept_next   = 1'b1;
				map_done_next = 1'b1;
			end
		end
	end

	// ==========================================================
	// Pin mapping registers
	// The single-change lock lasts until the next reset
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			map_done_reg <= 1'b0;
			accept_reg   <= 1'b0;
		end else begin
			map_done_reg <= map_done_next;
			accept_reg   <= accept_next;
		end
	end

	// ==========================================================
	// Decode
	always_comb begin
		dec_next = '0;
		// Source table and its PLL / primary flags kept side by side
		unique case (cfg_reg.osc_source_select)
			SRC_FAST_DIVN: begin
				dec_next.clk_source = CLK_FAST_DIVN; // [R1]
			end
			SRC_FAST_DIV16: begin
				dec_next.clk_source = CLK_FAST_DIV16; // [R1]
			end
			SRC_LOW_POWER: begin
				dec_next.clk_source = CLK_LOW_POWER; // [R1]
			end
			SRC_PRI_PLL: begin
				dec_next.clk_source       = CLK_PRI_PLL; // [R3]
				dec_next.src_uses_pll     = 1'b1; // [R3]
				dec_next.src_uses_primary = 1'b1; // [R3]
			end
			SRC_PRI: begin
				dec_next.clk_source       = CLK_PRI; // [R3]
				dec_next.src_uses_primary = 1'b1; // [R3]
			end
			SRC_FAST_DIVN_PLL: begin
				dec_next.clk_source   = CLK_FAST_DIVN_PLL; // [R3]
				dec_next.src_uses_pll = 1'b1; // [R3]
			end
			SRC_FAST: begin
				dec_next.clk_source = CLK_FAST; // [R3]
			end
			default: begin
				// Reserved code: flag it, fall back to plain fast RC so the core still runs
				dec_next.clk_source   = CLK_FAST; // [R2]
				dec_next.src_reserved = 1'b1; // [R2]
			end
		endcase

		// Upper bit set locks the clock tree: no switching and no monitor
		if (cfg_reg.clk_switch_monitor_mode[CKSM_DIS_BIT]) begin // [R4]
			dec_next.clk_switch_enable = 1'b0;
			dec_next.fail_safe_enable  = 1'b0;
		end else begin
			dec_next.clk_switch_enable = 1'b1; // [R4]
			dec_next.fail_safe_enable  = (cfg_reg.clk_switch_monitor_mode == CKSM_SW_FSCM); // [R4]
		end

		unique case (cfg_reg.primary_osc_mode)
			PRI_OFF: begin
				dec_next.pri_mode       = PMODE_OFF; // [R7]
				dec_next.primary_enable = 1'b0; // [R7]
			end
			PRI_XTAL_HIGH: begin
				dec_next.pri_mode       = PMODE_XTAL_HIGH; // [R7]
				dec_next.primary_enable = 1'b1; // [R7]
			end
			PRI_XTAL_MID: begin
				dec_next.pri_mode       = PMODE_XTAL_MID; // [R7]
				dec_next.primary_enable = 1'b1; // [R7]
			end
			PRI_EXT_CLK: begin
				dec_next.pri_mode       = PMODE_EXT_CLK; // [R7]
				dec_next.primary_enable = 1'b1; // [R7]
			end
		endcase

		// Crystal modes own the pin for the resonator, so neither clock out nor GPIO
		// Primary off frees the pin just as external clock mode does
		if (dec_next.pri_mode == PMODE_XTAL_HIGH || dec_next.pri_mode == PMODE_XTAL_MID) begin // [R6]
			dec_next.pin_clk_out = 1'b0;
			dec_next.pin_gpio    = 1'b0;
		end else begin
			dec_next.pin_clk_out = cfg_reg.second_osc_pin_pin_function; // [R6]
			dec_next.pin_gpio    = !cfg_reg.second_osc_pin_pin_function; // [R6]
		end
	end

	// ==========================================================
	// Decode registers
	// Every decoded output comes straight from a flip-flop
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			dec_reg <= '0;
		end else begin
			dec_reg <= dec_next;
		end
	end

	// ==========================================================
	// Outputs
	assign pin_map_write_accept = accept_reg;
	assign cfg_loaded           = loaded_reg;
	assign decoded              = dec_reg;

endmodule : osc_config_decode

`default_nettype wire

// ### design/osc_config_pkg.sv
// Package: configuration field codes and decoded types for the oscillator decode
package osc_config_pkg;

	// ==========================================================
	// Field widths and codes
	localparam int unsigned SRC_W  = 3;
	localparam int unsigned MODE_W = 2;

	localparam logic [2:0] SRC_FAST_DIVN     = 3'h7;
	localparam logic [2:0] SRC_FAST_DIV16    = 3'h6;
	localparam logic [2:0] SRC_LOW_POWER     = 3'h5;
	localparam logic [2:0] SRC_RESERVED      = 3'h4;
	localparam logic [2:0] SRC_PRI_PLL       = 3'h3;
	localparam logic [2:0] SRC_PRI           = 3'h2;
	localparam logic [2:0] SRC_FAST_DIVN_PLL = 3'h1;
	localparam logic [2:0] SRC_FAST          = 3'h0;

	localparam logic [1:0] CKSM_SW_FSCM     = 2'h0;
	localparam logic [1:0] CKSM_SW_ONLY     = 2'h1;
	localparam int unsigned CKSM_DIS_BIT    = 1;

	localparam logic [1:0] PRI_OFF          = 2'h3;
	localparam logic [1:0] PRI_XTAL_HIGH    = 2'h2;
	localparam logic [1:0] PRI_XTAL_MID     = 2'h1;
	localparam logic [1:0] PRI_EXT_CLK      = 2'h0;

	// ==========================================================
	// Reset values of the captured fields (safe: plain fast RC, no switching, primary off)
	localparam logic [2:0] SRC_RST          = 3'h0;
	localparam logic [1:0] CKSM_RST         = 2'h3;
	localparam logic       LOCK_RST         = 1'h1;
	localparam logic       FNC_RST          = 1'h0;
	localparam logic [1:0] PRI_RST          = 2'h3;

	// ==========================================================
	// Decoded clock source
	typedef enum logic [3:0] {
		CLK_FAST          = 4'h0,
		CLK_FAST_DIVN_PLL = 4'h1,
		CLK_PRI           = 4'h2,
		CLK_PRI_PLL       = 4'h3,
		CLK_LOW_POWER     = 4'h4,
		CLK_FAST_DIV16    = 4'h5,
		CLK_FAST_DIVN     = 4'h6,
		CLK_INVALID       = 4'hf
	} clk_source_t;

	typedef enum logic [1:0] {
		PMODE_EXT_CLK   = 2'h0,
		PMODE_XTAL_MID  = 2'h1,
		PMODE_XTAL_HIGH = 2'h2,
		PMODE_OFF       = 2'h3
	} pri_mode_t;

	// Raw configuration word as read from nonvolatile memory
	typedef struct packed {
		logic [2:0] osc_source_select;
		logic [1:0] clk_switch_monitor_mode;
		logic       pin_map_single_change;
		logic       second_osc_pin_pin_function;
		logic [1:0] primary_osc_mode;
	} osc_cfg_t;

	localparam osc_cfg_t CFG_RST = '{SRC_RST, CKSM_RST, LOCK_RST, FNC_RST, PRI_RST};

	// Decoded outputs
	typedef struct packed {
		clk_source_t clk_source;
		logic        src_uses_pll;
		logic        src_uses_primary;
		logic        src_reserved;
		logic        clk_switch_enable;
		logic        fail_safe_enable;
		pri_mode_t   pri_mode;
		logic        primary_enable;
		logic        pin_clk_out;
		logic        pin_gpio;
	} osc_decoded_t;

endpackage : osc_config_pkg

// ### testbench/osc_config_decode_sva.sv
// Checker: port assertions for the oscillator configuration decode
`timescale 1ns/1ns
`default_nettype none
module osc_config_decode_sva
	import osc_config_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst_n,
	input wire osc_cfg_t     cfg_word,
	input wire logic         cfg_valid,
	input wire logic         pin_map_write,
	input wire logic         pin_map_write_accept,
	input wire logic         cfg_loaded,
	input wire osc_decoded_t decoded
);
	// ==========================================
	// Shadow of the captured word, accept tally
	osc_cfg_t   cfg_reg;
	logic [1:0] acc_reg;
	logic       xtal;
	assign xtal = cfg_reg.primary_osc_mode inside {PRI_XTAL_MID, PRI_XTAL_HIGH};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= CFG_RST;
			acc_reg <= 2'h0;
		end else begin
			if (cfg_valid && !cfg_loaded)
				cfg_reg <= cfg_word;
			if (pin_map_write_accept && acc_reg != 2'h3)
				acc_reg <= acc_reg + 2'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence take_s; cfg_valid && !cfg_loaded; endsequence
	sequence ready_s; cfg_loaded && $past(cfg_loaded); endsequence
	load_follow_a: assert property (take_s |=> cfg_loaded) else $error("no load");
	load_hold_a: assert property (cfg_loaded |=> cfg_loaded) else $error("load lost");
	value_hold_a: assert property (ready_s |=> $stable(decoded)) else $error("drift");
	src_reserved_a: assert property (ready_s |-> decoded.src_reserved ==
		(cfg_reg.osc_source_select == SRC_RESERVED)) else $error("reserved flag");
	switch_mode_a: assert property (ready_s |-> decoded.clk_switch_enable ==
		!cfg_reg.clk_switch_monitor_mode[1] && decoded.fail_safe_enable ==
		(cfg_reg.clk_switch_monitor_mode == CKSM_SW_FSCM)) else $error("switch mode");
	pri_mode_a: assert property (ready_s |->
		decoded.pri_mode == cfg_reg.primary_osc_mode) else $error("primary mode");
	pin_func_a: assert property (ready_s |-> decoded.pin_clk_out ==
		(cfg_reg.second_osc_pin_pin_function && !xtal)) else $error("pin function");
	multi_accept_a: assert property (pin_map_write && cfg_loaded &&
		!cfg_reg.pin_map_single_change |=> pin_map_write_accept) else $error("refused");
	one_change_a: assert property (cfg_reg.pin_map_single_change |->
		acc_reg < 2'h2) else $error("second change");
endmodule : osc_config_decode_sva
bind osc_config_decode osc_config_decode_sva chk (.clk, .rst_n, .cfg_word, .cfg_valid,
	.pin_map_write, .pin_map_write_accept, .cfg_loaded, .decoded);
`default_nettype wire

// ### testbench/osc_config_decode_bench.sv
// Bench: self-checking test of the oscillator configuration decode
`timescale 1ns/1ns
`default_nettype none
module osc_config_decode_bench;
	import osc_config_pkg::*;
	logic         clk, rst_n, cfg_valid, pin_map_write, pin_map_write_accept, cfg_loaded;
	osc_cfg_t     cfg_word, c;
	osc_decoded_t decoded;
	osc_decoded_t exp_q[$];
	int           bad_count, checks_done, acc;
	clk_source_t  src_tab[0:7] = '{CLK_FAST, CLK_FAST_DIVN_PLL, CLK_PRI, CLK_PRI_PLL,
		CLK_FAST, CLK_LOW_POWER, CLK_FAST_DIV16, CLK_FAST_DIVN};
	osc_config_decode uut (.clk, .rst_n, .cfg_word, .cfg_valid, .pin_map_write,
		.pin_map_write_accept, .cfg_loaded, .decoded);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ==========================================
	// Expected decode and comparison
	function automatic osc_decoded_t exp_dec(osc_cfg_t w);
		osc_decoded_t d;
		logic         x;
		x = w.primary_osc_mode inside {PRI_XTAL_MID, PRI_XTAL_HIGH};
		d.clk_source = src_tab[w.osc_source_select];
		d.src_uses_pll = w.osc_source_select inside {SRC_PRI_PLL, SRC_FAST_DIVN_PLL};
		d.src_uses_primary = w.osc_source_select inside {SRC_PRI_PLL, SRC_PRI};
		d.src_reserved = w.osc_source_select == SRC_RESERVED;
		d.clk_switch_enable = !w.clk_switch_monitor_mode[1];
		d.fail_safe_enable = w.clk_switch_monitor_mode == CKSM_SW_FSCM;
		d.pri_mode = pri_mode_t'(w.primary_osc_mode);
		d.primary_enable = w.primary_osc_mode != PRI_OFF;
		d.pin_clk_out = w.second_osc_pin_pin_function && !x;
		d.pin_gpio = !w.second_osc_pin_pin_function && !x;
		return d;
	endfunction : exp_dec
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	// Decoded word lands one edge after the load flag
	always @(posedge cfg_loaded) begin
		@(posedge clk);
		#1;
		chk(16'(decoded), 16'(exp_q.pop_front()));
	end
	always @(posedge clk) begin
		if (!rst_n)
			acc = 0;
		else if (pin_map_write_accept === 1'b1)
			acc++;
	end
	initial begin
		#100000;
		bad_count++;
		end_sim();
	end
	// ==========================================
	// One reset per case: every source code except reserved 100, and every mode
	initial begin
		// High first, so the first reset is a real falling edge for the design
		rst_n = 1'b1;
		{cfg_valid, pin_map_write} = '0;
		cfg_word = CFG_RST;
		void'($urandom(13));
		for (int i = 0; i < 8; i++) begin
			c = osc_cfg_t'(9'($urandom));
			c.osc_source_select = (i == 4) ? SRC_PRI : 3'(i);
			c.clk_switch_monitor_mode = 2'(i);
			c.primary_osc_mode = 2'(i >> 1);
			c.pin_map_single_change = i[0];
			rst_n <= 1'b0;
			repeat (10) @(posedge clk);
			rst_n <= 1'b1;
			repeat (3) @(posedge clk);
			cfg_word <= c;
			cfg_valid <= 1'b1;
			exp_q.push_back(exp_dec(c));
			@(posedge clk);
			// Late second word must be ignored; its source field stays off the reserved code
			cfg_word <= c ^ 9'h03f;
			@(posedge clk);
			cfg_valid <= 1'b0;
			pin_map_write <= 1'b1;
			repeat (3) @(posedge clk);
			pin_map_write <= 1'b0;
			repeat (3) @(posedge clk);
			chk(16'(acc), c.pin_map_single_change ? 16'h1 : 16'h3);
			chk(16'(decoded), 16'(exp_dec(c)));
			chk(16'(cfg_loaded), 16'h1);
			chk(16'(exp_q.size()), 16'h0);
			$display("test %0d done", i);
		end
		end_sim();
	end
endmodule : osc_config_decode_bench
`default_nettype wire
